// ### hdl/ep0_csr_pkg.sv
package ep0_csr_pkg;

    // Bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int INT_W = 4;

    // Register index as printed, byte address derived
    localparam logic [ADDR_W-1:0] CSR_IDX = 12'h102;
    localparam logic [ADDR_W-1:0] CSR_ADDR = 12'(CSR_IDX * 4);
    localparam logic [ADDR_W-1:0] CFG_ADDR = 12'h400;
    localparam logic [ADDR_W-1:0] INT_STS_ADDR = 12'h410;
    localparam logic [ADDR_W-1:0] INT_MSK_ADDR = 12'h414;

    // Low control byte fields, shared positions
    localparam int B_RX_RDY = 0;
    localparam int B_TX_RDY = 1;
    localparam int B_STALL = 2;
    localparam int B_SETUP = 3;
    localparam int B_DATA_END = 3;
    localparam int B_ERR = 4;
    localparam int B_SETUP_END = 4;
    localparam int B_IN_REQ = 5;
    localparam int B_SEND_STALL = 5;
    localparam int B_STATUS = 6;
    localparam int B_RX_CLR = 6;
    localparam int B_NAK_TO = 7;
    localparam int B_SETUP_END_CLR = 7;

    // Configuration and interrupt fields
    localparam int B_HOST_ROLE = 0;
    localparam int I_TX_DONE = 0;
    localparam int I_RX_PKT = 1;
    localparam int I_NO_RESP = 2;
    localparam int I_SETUP_END = 3;

    // Reset values
    localparam logic [7:0] CSR_RESET = 8'h00;
    localparam logic [INT_W-1:0] INT_RESET = 4'h0;

    // Responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_CSR,
        SEL_CFG,
        SEL_STS,
        SEL_MSK
    } reg_sel_e;

    // Events reported by the packet engine
    typedef struct packed {
        logic tx_done;
        logic rx_packet;
        logic stall_rx;
        logic no_response;
        logic nak_limit;
        logic ctrl_end_early;
        logic stall_sent;
        logic stage_done;
    } ep0_ev_s;

    // Commands to the packet engine
    typedef struct packed {
        logic host_role;
        logic in_request;
        logic tx_ready;
        logic setup_token;
        logic status_stage;
        logic toggle_force_one;
        logic toggle_reset;
        logic halted;
        logic send_stall;
        logic data_end;
        logic fifo_flush;
    } ep0_cmd_s;

endpackage : ep0_csr_pkg

// ### hdl/ep0_ctrl_status_low.sv
`timescale 1ns/1ns
`default_nettype none

module ep0_ctrl_status_low
    import ep0_csr_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // AXI4-Lite write address and data
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Packet engine
    input wire ep0_ev_s ev,
    output ep0_cmd_s cmd,
    // Interrupt
    output logic irq
);

    function automatic reg_sel_e decode(input logic [ADDR_W-1:0] a);
        reg_sel_e s;
        s = SEL_NONE;
        case (a)
            CSR_ADDR: s = SEL_CSR;
            CFG_ADDR: s = SEL_CFG;
            INT_STS_ADDR: s = SEL_STS;
            INT_MSK_ADDR: s = SEL_MSK;
            default: s = SEL_NONE;
        endcase
        return s;
    endfunction : decode

    // Bus state
    logic aw_have_q, w_have_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [3:0] wstrb_q;
    logic aw_hs, w_hs, ar_hs, wr_fire;
    logic aw_have_d, w_have_d, bvalid_d, rvalid_d;
    reg_sel_e wsel, rsel;

    // Control byte state
    logic host_q;
    logic nak_to_q, status_q, in_req_q, err_q, setup_q;
    logic stalled_q, tx_ready_q, rx_ready_q;
    logic send_stall_q, setup_end_q, data_end_q;
    logic force_one_q, toggle_rst_q, flush_q;
    logic [INT_W-1:0] int_sts_q, int_msk_q, int_ev;
    logic [7:0] csr_view;
    logic [DATA_W-1:0] rd_val;

    // Write strobes
    logic we_csr, we_cfg, we_sts, we_msk;
    logic [7:0] wd;
    logic h_we, d_we;

    assign aw_hs = s_axi_awvalid & s_axi_awready;
    assign w_hs = s_axi_wvalid & s_axi_wready;
    assign ar_hs = s_axi_arvalid & s_axi_arready;
    assign wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;
    assign wsel = decode(awaddr_q);
    assign rsel = decode(s_axi_araddr);
    assign wd = wdata_q[7:0];
    assign we_csr = wr_fire & (wsel == SEL_CSR) & wstrb_q[0];
    assign we_cfg = wr_fire & (wsel == SEL_CFG) & wstrb_q[0];
    assign we_sts = wr_fire & (wsel == SEL_STS) & wstrb_q[0];
    assign we_msk = wr_fire & (wsel == SEL_MSK) & wstrb_q[0];
    assign h_we = we_csr & host_q;
    assign d_we = we_csr & ~host_q;

    assign aw_have_d = aw_hs | (aw_have_q & ~wr_fire);
    assign w_have_d = w_hs | (w_have_q & ~wr_fire);
    assign bvalid_d = wr_fire | (s_axi_bvalid & ~s_axi_bready);
    assign rvalid_d = ar_hs | (s_axi_rvalid & ~s_axi_rready);

    // Write channel handshake
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            s_axi_awready <= ~aw_have_d;
            s_axi_wready <= ~w_have_d;
            s_axi_bvalid <= bvalid_d;
            if (aw_hs) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (w_hs) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                s_axi_bresp <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            end
        end
    end

    // Read channel
    always_comb begin
        case (rsel)
            SEL_CSR: rd_val = {24'h0, csr_view};
            SEL_CFG: rd_val = {31'h0, host_q};
            SEL_STS: rd_val = {28'h0, int_sts_q};
            SEL_MSK: rd_val = {28'h0, int_msk_q};
            default: rd_val = '0;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= ~rvalid_d;
            s_axi_rvalid <= rvalid_d;
            if (ar_hs) begin
                s_axi_rdata <= rd_val;
                s_axi_rresp <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            end
        end
    end

    // Role-dependent view of the control byte
    always_comb begin
        if (host_q) begin
            csr_view = {nak_to_q, status_q, in_req_q, err_q, setup_q,
                        stalled_q, tx_ready_q, rx_ready_q};
        end else begin
            csr_view = {2'b00, send_stall_q, setup_end_q, data_end_q,
                        stalled_q, tx_ready_q, rx_ready_q};
        end
    end

    // Role selection
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            host_q <= 1'b0;
        end else if (we_cfg) begin
            host_q <= wd[B_HOST_ROLE];
        end
    end

    // Host-only bits
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            nak_to_q <= CSR_RESET[B_NAK_TO];
            status_q <= CSR_RESET[B_STATUS];
            in_req_q <= CSR_RESET[B_IN_REQ];
            err_q <= CSR_RESET[B_ERR];
            setup_q <= CSR_RESET[B_SETUP];
        end else begin
            if (host_q & ev.nak_limit) begin
                nak_to_q <= 1'b1;
            end else if (h_we & ~wd[B_NAK_TO]) begin
                nak_to_q <= 1'b0;
            end
            if (h_we) begin
                status_q <= wd[B_STATUS];
            end
            if (h_we) begin
                in_req_q <= wd[B_IN_REQ];
            end else if (host_q & ev.rx_packet) begin
                in_req_q <= 1'b0;
            end
            if (host_q & ev.no_response) begin
                err_q <= 1'b1;
            end else if (h_we & ~wd[B_ERR]) begin
                err_q <= 1'b0;
            end
            if (h_we & wd[B_SETUP]) begin
                setup_q <= 1'b1;
            end else if (host_q & ev.tx_done) begin
                setup_q <= 1'b0;
            end
        end
    end

    // Shared handshake bits
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stalled_q <= CSR_RESET[B_STALL];
            tx_ready_q <= CSR_RESET[B_TX_RDY];
            rx_ready_q <= CSR_RESET[B_RX_RDY];
        end else begin
            if (host_q ? ev.stall_rx : ev.stall_sent) begin
                stalled_q <= 1'b1;
            end else if (we_csr & ~wd[B_STALL]) begin
                stalled_q <= 1'b0;
            end
            if (we_csr & wd[B_TX_RDY]) begin
                tx_ready_q <= 1'b1;
            end else if (ev.tx_done) begin
                tx_ready_q <= 1'b0;
            end
            if (ev.rx_packet) begin
                rx_ready_q <= 1'b1;
            end else if (h_we & ~wd[B_RX_RDY]) begin
                rx_ready_q <= 1'b0;
            end else if (d_we & wd[B_RX_CLR]) begin
                rx_ready_q <= 1'b0;
            end
        end
    end

    // Device-only bits
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            send_stall_q <= CSR_RESET[B_SEND_STALL];
            setup_end_q <= CSR_RESET[B_SETUP_END];
            data_end_q <= CSR_RESET[B_DATA_END];
        end else begin
            if (d_we & wd[B_SEND_STALL]) begin
                send_stall_q <= 1'b1;
            end else if (ev.stall_sent) begin
                send_stall_q <= 1'b0;
            end
            if (~host_q & ev.ctrl_end_early & ~data_end_q) begin
                setup_end_q <= 1'b1;
            end else if (d_we & wd[B_SETUP_END_CLR]) begin
                setup_end_q <= 1'b0;
            end
            if (d_we & wd[B_DATA_END]) begin
                data_end_q <= 1'b1;
            end else if (ev.stage_done | ev.ctrl_end_early) begin
                data_end_q <= 1'b0;
            end
        end
    end

    // One-cycle commands to the packet engine
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            force_one_q <= 1'b0;
            toggle_rst_q <= 1'b0;
            flush_q <= 1'b0;
        end else begin
            force_one_q <= h_we & wd[B_STATUS]
                           & (wd[B_TX_RDY] | wd[B_IN_REQ]);
            toggle_rst_q <= h_we & wd[B_SETUP] & wd[B_TX_RDY];
            flush_q <= ~host_q & ev.ctrl_end_early & ~data_end_q;
        end
    end

    assign cmd.host_role = host_q;
    assign cmd.in_request = in_req_q;
    assign cmd.tx_ready = tx_ready_q;
    assign cmd.setup_token = setup_q;
    assign cmd.status_stage = status_q;
    assign cmd.toggle_force_one = force_one_q;
    assign cmd.toggle_reset = toggle_rst_q;
    assign cmd.halted = nak_to_q;
    assign cmd.send_stall = send_stall_q;
    assign cmd.data_end = data_end_q;
    assign cmd.fifo_flush = flush_q;

    // Interrupt sources
    always_comb begin
        int_ev = '0;
        int_ev[I_TX_DONE] = ev.tx_done & tx_ready_q;
        int_ev[I_RX_PKT] = ev.rx_packet;
        int_ev[I_NO_RESP] = host_q & ev.no_response;
        int_ev[I_SETUP_END] = ~host_q & ev.ctrl_end_early & ~data_end_q;
    end

    // Sticky status, write one to clear, set wins
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            int_sts_q <= INT_RESET;
        end else begin
            int_sts_q <= int_ev
                         | (int_sts_q & ~(we_sts ? wd[INT_W-1:0] : '0));
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            int_msk_q <= INT_RESET;
        end else if (we_msk) begin
            int_msk_q <= wd[INT_W-1:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_sts_q & int_msk_q);
        end
    end

    // Checks
    chk_nak_halts: assert property (
        @(posedge core_clk) disable iff (rst)
        host_q && ev.nak_limit |=> nak_to_q && cmd.halted)
        else $error("NAK limit did not halt endpoint");

    chk_status_toggle: assert property (
        @(posedge core_clk) disable iff (rst)
        h_we && wd[B_STATUS] && (wd[B_TX_RDY] || wd[B_IN_REQ])
            |=> force_one_q ##1 !force_one_q || $past(h_we))
        else $error("Status stage did not force toggle one");

    chk_in_clear: assert property (
        @(posedge core_clk) disable iff (rst)
        host_q && ev.rx_packet && !h_we |=> !in_req_q && rx_ready_q)
        else $error("IN request not cleared on receive");

    chk_err_irq: assert property (
        @(posedge core_clk) disable iff (rst)
        host_q && ev.no_response && int_msk_q[I_NO_RESP] && !we_msk
            |=> err_q ##1 irq)
        else $error("No-response error did not raise interrupt");

    chk_setup_reset: assert property (
        @(posedge core_clk) disable iff (rst)
        h_we && wd[B_SETUP] && wd[B_TX_RDY]
            |=> toggle_rst_q && setup_q && tx_ready_q)
        else $error("Setup token did not reset toggle");

    chk_tx_clear: assert property (
        @(posedge core_clk) disable iff (rst)
        ev.tx_done && tx_ready_q && !(we_csr && wd[B_TX_RDY])
            |=> !tx_ready_q && int_sts_q[I_TX_DONE])
        else $error("Transmit ready not cleared after send");

    chk_rx_w0c: assert property (
        @(posedge core_clk) disable iff (rst)
        h_we && !wd[B_RX_RDY] && !ev.rx_packet |=> !rx_ready_q)
        else $error("Host receive ready not cleared by write zero");

    chk_rx_device: assert property (
        @(posedge core_clk) disable iff (rst)
        !host_q && rx_ready_q && !(d_we && wd[B_RX_CLR]) |=> rx_ready_q)
        else $error("Device receive ready lost without clear");

    chk_setup_end_flush: assert property (
        @(posedge core_clk) disable iff (rst)
        !host_q && ev.ctrl_end_early && !data_end_q |=> setup_end_q && flush_q
            ##1 !flush_q || $past(ev.ctrl_end_early))
        else $error("Early end did not flag and flush");

    chk_stall_sticky: assert property (
        @(posedge core_clk) disable iff (rst)
        !host_q && stalled_q && !(d_we && !wd[B_STALL]) |=> stalled_q)
        else $error("Stall sent flag dropped without write zero");

    chk_reset_zero: assert property (
        @(posedge core_clk)
        $fell(rst) |-> csr_view == CSR_RESET)
        else $error("Control byte not zero after reset");

endmodule : ep0_ctrl_status_low

`default_nettype wire

// ### bench/ep0_peer_model.sv
`timescale 1ns/1ns
`default_nettype none
module ep0_peer_model
    import ep0_csr_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Block side
    input wire ep0_cmd_s cmd,
    output ep0_ev_s ev,
    // Bench control
    input wire ep0_ev_s inject,
    input wire logic [3:0] delay
);
    logic [3:0] wait_q;
    logic done_q;
    logic busy;

    // No service while the endpoint is halted
    assign busy = (cmd.tx_ready | cmd.in_request | cmd.send_stall)
        & !cmd.halted;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ev <= '0;
            wait_q <= '0;
            done_q <= 1'b0;
        end else begin
            ev <= inject;
            if (!busy) begin
                wait_q <= '0;
                done_q <= 1'b0;
            end else if (!done_q && wait_q == delay) begin
                done_q <= 1'b1;
                ev.tx_done <= cmd.tx_ready;
                ev.rx_packet <= cmd.in_request;
                ev.stall_sent <= cmd.send_stall;
            end else if (!done_q) begin
                wait_q <= wait_q + 4'h1;
            end
        end
    end
endmodule : ep0_peer_model
`default_nettype wire

// ### bench/usb_ep0_control_status_low_test.sv
`timescale 1ns/1ns
`default_nettype none
module usb_ep0_control_status_low_test
    import ep0_csr_pkg::*;
;
    logic core_clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    ep0_ev_s ev, inject;
    ep0_cmd_s cmd;
    logic [3:0] peer_delay;
    logic [3:0] strb;
    int errors, samples_checked, n_flush, n_tog0, n_tog1, mark;
    localparam logic [7:0] EV_STAGE = 8'h01, EV_EARLY = 8'h04;
    localparam logic [7:0] EV_NAK = 8'h08, EV_NORESP = 8'h10;
    localparam logic [7:0] EV_STALLRX = 8'h20, EV_RX = 8'h40;

    ep0_ctrl_status_low uut (.core_clk(core_clk), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ev(ev), .cmd(cmd),
        .irq(irq));

    ep0_peer_model peer (.core_clk(core_clk), .rst(rst), .cmd(cmd),
        .ev(ev), .inject(inject), .delay(peer_delay));

    always #5 core_clk = ~core_clk;

    // Pulse counters
    always @(posedge core_clk) begin
        if (cmd.fifo_flush === 1'b1) n_flush++;
        if (cmd.toggle_reset === 1'b1) n_tog0++;
        if (cmd.toggle_force_one === 1'b1) n_tog1++;
    end

    task automatic wrap_up;
        if (errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [7:0] d,
        input logic [1:0] er = RESP_OKAY);
        int n;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge core_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                chk("bresp", 32'(er), 32'(bresp));
                break;
            end
        end
        if (n == 40) begin
            errors++;
            wrap_up();
        end
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [7:0] d,
        input string what, input logic [1:0] er = RESP_OKAY);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge core_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                chk(what, {24'h0, d}, rdata);
                chk("rresp", 32'(er), 32'(rresp));
                break;
            end
        end
        if (n == 40) begin
            errors++;
            wrap_up();
        end
    endtask : rd

    task automatic pulse(input logic [7:0] e);
        inject <= ep0_ev_s'(e);
        @(posedge core_clk);
        inject <= '0;
        repeat (2) @(posedge core_clk);
    endtask : pulse

    task automatic wait_idle;
        int n;
        for (n = 0; n < 40; n++) begin
            @(posedge core_clk);
            if (!(cmd.tx_ready || cmd.in_request || cmd.send_stall)) break;
        end
        if (n == 40) begin
            errors++;
            wrap_up();
        end
    endtask : wait_idle

    task automatic chk_irq(input logic exp);
        @(posedge core_clk);
        chk("irq", 32'(exp), 32'(irq));
    endtask : chk_irq

    task automatic t_reset;
        rd(CSR_ADDR, 8'h00, "csr");
        rd(CFG_ADDR, 8'h00, "cfg");
        rd(INT_STS_ADDR, 8'h00, "sts");
        rd(INT_MSK_ADDR, 8'h00, "msk");
        rd(12'h7fc, 8'h00, "unmapped", RESP_SLVERR);
        wr(12'h7fc, 8'hff, RESP_SLVERR);
        wr(INT_MSK_ADDR, 8'h0f);
    endtask : t_reset

    task automatic t_dev_tx;
        peer_delay <= 4'h9;
        wr(CSR_ADDR, 8'h0a);
        wait_idle();
        rd(CSR_ADDR, 8'h08, "csr");
        chk_irq(1'b1);
        rd(INT_STS_ADDR, 8'h01, "sts");
        pulse(EV_STAGE);
        rd(CSR_ADDR, 8'h00, "csr");
        wr(INT_STS_ADDR, 8'h01);
        chk_irq(1'b0);
    endtask : t_dev_tx

    task automatic t_dev_rx_stall;
        peer_delay <= 4'h0;
        pulse(EV_RX);
        rd(CSR_ADDR, 8'h01, "csr");
        rd(INT_STS_ADDR, 8'h02, "sts");
        wr(CSR_ADDR, 8'h00);
        rd(CSR_ADDR, 8'h01, "csr");
        wr(CSR_ADDR, 8'h40);
        rd(CSR_ADDR, 8'h00, "csr");
        wr(INT_STS_ADDR, 8'h02);
        wr(CSR_ADDR, 8'h20);
        wait_idle();
        rd(CSR_ADDR, 8'h04, "csr");
        wr(CSR_ADDR, 8'h00);
        rd(CSR_ADDR, 8'h00, "csr");
        wr(CSR_ADDR, 8'h04);
        rd(CSR_ADDR, 8'h00, "csr");
    endtask : t_dev_rx_stall

    task automatic t_setup_end;
        mark = n_flush;
        pulse(EV_EARLY);
        rd(CSR_ADDR, 8'h10, "csr");
        rd(INT_STS_ADDR, 8'h08, "sts");
        chk("flush", 32'(mark + 1), 32'(n_flush));
        wr(CSR_ADDR, 8'h80);
        rd(CSR_ADDR, 8'h00, "csr");
        wr(INT_STS_ADDR, 8'h08);
        wr(CSR_ADDR, 8'h08);
        pulse(EV_EARLY);
        rd(CSR_ADDR, 8'h00, "csr");
        chk("flush", 32'(mark + 1), 32'(n_flush));
    endtask : t_setup_end

    task automatic t_host_xfer;
        wr(CFG_ADDR, 8'h01);
        peer_delay <= 4'h5;
        mark = n_tog0;
        wr(CSR_ADDR, 8'h0a);
        wait_idle();
        chk("toggle_reset", 32'(mark + 1), 32'(n_tog0));
        rd(CSR_ADDR, 8'h00, "csr");
        rd(INT_STS_ADDR, 8'h01, "sts");
        wr(INT_STS_ADDR, 8'h01);
        mark = n_tog1;
        wr(CSR_ADDR, 8'h60);
        wait_idle();
        chk("toggle_one", 32'(mark + 1), 32'(n_tog1));
        rd(CSR_ADDR, 8'h41, "csr");
        rd(INT_STS_ADDR, 8'h02, "sts");
        wr(CSR_ADDR, 8'h00);
        rd(CSR_ADDR, 8'h00, "csr");
        wr(INT_STS_ADDR, 8'h02);
    endtask : t_host_xfer

    task automatic t_host_fault;
        peer_delay <= 4'h0;
        pulse(EV_STALLRX);
        pulse(EV_NORESP);
        rd(CSR_ADDR, 8'h14, "csr");
        rd(INT_STS_ADDR, 8'h04, "sts");
        chk_irq(1'b1);
        wr(INT_MSK_ADDR, 8'h0b);
        chk_irq(1'b0);
        wr(INT_MSK_ADDR, 8'h0f);
        wr(INT_STS_ADDR, 8'h04);
        wr(CSR_ADDR, 8'h00);
        rd(CSR_ADDR, 8'h00, "csr");
        pulse(EV_NAK);
        chk("halted", 32'h1, 32'(cmd.halted));
        wr(CSR_ADDR, 8'h82);
        rd(CSR_ADDR, 8'h82, "csr");
        wr(CSR_ADDR, 8'h02);
        wait_idle();
        rd(CSR_ADDR, 8'h00, "csr");
    endtask : t_host_fault

    task automatic t_mid_reset;
        strb <= 4'h0;
        wr(CSR_ADDR, 8'h40);
        strb <= 4'h1;
        rd(CSR_ADDR, 8'h00, "csr_no_strobe");
        wr(CSR_ADDR, 8'h40);
        rd(CSR_ADDR, 8'h40, "csr");
        chk_irq(1'b1);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        chk_irq(1'b0);
        rd(CSR_ADDR, 8'h00, "csr");
        rd(CFG_ADDR, 8'h00, "cfg");
        rd(INT_STS_ADDR, 8'h00, "sts");
    endtask : t_mid_reset

    initial begin
        core_clk = 1'b0;
        rst = 1'b1;
        {awvalid, wvalid, arvalid} = '0;
        {bready, rready} = 2'h3;
        {awaddr, araddr, wdata} = '0;
        inject = '0;
        peer_delay = 4'h0;
        strb = 4'h1;
        {errors, samples_checked, n_flush, n_tog0, n_tog1, mark} = '0;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        t_reset();
        t_dev_tx();
        t_dev_rx_stall();
        t_setup_end();
        t_host_xfer();
        t_host_fault();
        t_mid_reset();
        wrap_up();
    end
endmodule : usb_ep0_control_status_low_test
`default_nettype wire
